// file: gmsc_top.sv
// Pin function map and spur reduction register group
// Functional notes
// - Bits 6:0 of each pin map register index one table bit.
// - Control and status tables hold 128 single-bit entries each.
// - Bit 7 zero: pin drives control bit; one: pin shows status bit.
// - Pin map registers reset to 0x00, leaving the pin unused.
// - Changing the spur setting starts a 200 ms reconfiguration.
module gmsc_top
    import gmsc_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     ce_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    output logic      [7:0]               reg_rdata_o,
    output logic                          reconfig_busy_o,
    output logic      [7:0]               spur_setting_o,
    input  wire logic [TABLE_ENTRIES-1:0] status_table_i,
    output logic      [TABLE_ENTRIES-1:0] control_table_o,
    input  wire logic                     general_pin_nine_i,
    output logic                          general_pin_nine_o,
    output logic                          general_pin_nine_oe_o,
    input  wire logic                     general_pin_ten_i,
    output logic                          general_pin_ten_o,
    output logic                          general_pin_ten_oe_o,
    input  wire logic                     general_pin_eleven_i,
    output logic                          general_pin_eleven_o,
    output logic                          general_pin_eleven_oe_o
);
    // ==========================================================
    // Declarations
    logic [7:0]                map_r [PIN_COUNT];
    logic [7:0]                map_nxt [PIN_COUNT];
    logic [7:0]                spur_r;
    logic [7:0]                spur_nxt;
    logic [7:0]                rdata_r;
    logic [7:0]                rdata_nxt;
    logic [TABLE_ENTRIES-1:0]  ctrl_r;
    logic [TABLE_ENTRIES-1:0]  ctrl_nxt;
    gmsc_state_e               state_r;
    gmsc_state_e               state_nxt;
    logic [RECONFIG_CNT_W-1:0] cnt_r;
    logic [RECONFIG_CNT_W-1:0] cnt_nxt;
    logic                      busy_r;
    logic                      busy_nxt;
    logic [PIN_COUNT-1:0]      pin_raw;
    logic [PIN_COUNT-1:0]      s1_r;
    logic [PIN_COUNT-1:0]      s2_r;
    logic [PIN_COUNT-1:0]      s3_r;
    logic [PIN_COUNT-1:0]      pin_val_r;
    logic [PIN_COUNT-1:0]      pin_val_nxt;
    logic [PIN_COUNT-1:0]      pin_out;
    logic [PIN_COUNT-1:0]      pin_oe;
    logic [PIN_COUNT-1:0]      c_we;
    logic [TABLE_INDEX_MSB:0]  c_idx [PIN_COUNT];
    logic [PIN_COUNT-1:0]      c_val;
    logic                      access;

    assign pin_raw = {general_pin_eleven_i, general_pin_ten_i, general_pin_nine_i};
    assign access  = !busy_r;

    // ==========================================================
    // Pin input synchronisers
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pin_val_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_val_r[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_r      <= '0;
            s2_r      <= '0;
            s3_r      <= '0;
            pin_val_r <= '0;
        end else if (ce_i) begin
            s1_r      <= pin_raw;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            pin_val_r <= pin_val_nxt;
        end
    end

    // ==========================================================
    // Register writes and reads
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            map_nxt[i] = map_r[i];
        end
        spur_nxt  = spur_r;
        rdata_nxt = rdata_r;
        if (access && reg_wr_i) begin
            case (reg_addr_i)
                PIN9_FUNCTION_MAP_ADDR:      map_nxt[0] = reg_wdata_i;
                PIN10_FUNCTION_MAP_ADDR:     map_nxt[1] = reg_wdata_i;
                PIN11_FUNCTION_MAP_ADDR:     map_nxt[2] = reg_wdata_i;
                SPUR_REDUCTION_SETTING_ADDR: spur_nxt   = reg_wdata_i;
                default: ;
            endcase
        end
        if (access && reg_rd_i) begin
            case (reg_addr_i)
                PIN9_FUNCTION_MAP_ADDR:      rdata_nxt = map_r[0];
                PIN10_FUNCTION_MAP_ADDR:     rdata_nxt = map_r[1];
                PIN11_FUNCTION_MAP_ADDR:     rdata_nxt = map_r[2];
                SPUR_REDUCTION_SETTING_ADDR: rdata_nxt = spur_r;
                default:                     rdata_nxt = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                map_r[i] <= REG_RESET_VALUE;
            end
            spur_r  <= REG_RESET_VALUE;
            rdata_r <= UNMAPPED_READ_VALUE;
        end else if (ce_i) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                map_r[i] <= map_nxt[i];
            end
            spur_r  <= spur_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Reconfiguration timer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        case (state_r)
            GMSC_IDLE: begin
                if (access && reg_wr_i && reg_addr_i == SPUR_REDUCTION_SETTING_ADDR
                    && reg_wdata_i != spur_r) begin
                    state_nxt = GMSC_RECONFIG;
                    cnt_nxt   = RECONFIG_CYCLES - 1'b1;
                    busy_nxt  = 1'b1;
                end
            end
            GMSC_RECONFIG: begin
                if (cnt_r == '0) begin
                    state_nxt = GMSC_IDLE;
                    busy_nxt  = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = GMSC_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= GMSC_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // ==========================================================
    // Pin mapping
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        gmsc_pin_map u_map (
            .clk_i          (clk_i),
            .rst_n_i        (rst_n_i),
            .ce_i           (ce_i),
            .map_i          (map_r[g]),
            .pin_sync_i     (pin_val_r[g]),
            .status_table_i (status_table_i),
            .pin_o          (pin_out[g]),
            .pin_oe_o       (pin_oe[g]),
            .ctrl_we_o      (c_we[g]),
            .ctrl_idx_o     (c_idx[g]),
            .ctrl_val_o     (c_val[g])
        );
    end

    // Control table, later pins win on a shared index
    always_comb begin
        ctrl_nxt = ctrl_r;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (c_we[i]) begin
                ctrl_nxt[c_idx[i]] = c_val[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else if (ce_i) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o             = rdata_r;
    assign reconfig_busy_o         = busy_r;
    assign spur_setting_o          = spur_r;
    assign control_table_o         = ctrl_r;
    assign general_pin_nine_o      = pin_out[0];
    assign general_pin_nine_oe_o   = pin_oe[0];
    assign general_pin_ten_o       = pin_out[1];
    assign general_pin_ten_oe_o    = pin_oe[1];
    assign general_pin_eleven_o    = pin_out[2];
    assign general_pin_eleven_oe_o = pin_oe[2];
endmodule

// file: gmsc_pkg.sv
// Package for the pin function map and spur configuration register group
package gmsc_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] PIN9_FUNCTION_MAP_ADDR      = 8'he9;
    localparam logic [7:0] PIN10_FUNCTION_MAP_ADDR     = 8'hea;
    localparam logic [7:0] PIN11_FUNCTION_MAP_ADDR     = 8'heb;
    localparam logic [7:0] SPUR_REDUCTION_SETTING_ADDR = 8'hf7;
    localparam logic [7:0] REG_RESET_VALUE             = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;
    // ==========================================================
    // Field layout
    localparam int         TABLE_INDEX_MSB   = 6;
    localparam int         DIRECTION_BIT     = 7;
    localparam int         TABLE_ENTRIES     = 128;
    localparam int         PIN_COUNT         = 3;
    localparam logic       DIR_CONTROL       = 1'b0;
    localparam logic       DIR_STATUS        = 1'b1;
    // ==========================================================
    // Timing
    localparam longint     CLK_FREQ_HZ       = 10_000_000;
    localparam longint     RECONFIG_TIME_MS  = 200;
    localparam longint     RECONFIG_CYCLES_L = (RECONFIG_TIME_MS * CLK_FREQ_HZ) / 1000;
    localparam int         RECONFIG_CNT_W    = 22;
    localparam logic [RECONFIG_CNT_W-1:0] RECONFIG_CYCLES =
        RECONFIG_CYCLES_L[RECONFIG_CNT_W-1:0];
    typedef enum logic [0:0] {GMSC_IDLE, GMSC_RECONFIG} gmsc_state_e;
endpackage

// file: gmsc_pin_map.sv
// One general purpose pin mapped onto the control or status table
module gmsc_pin_map
    import gmsc_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     ce_i,
    input  wire logic [7:0]               map_i,
    input  wire logic                     pin_sync_i,
    input  wire logic [TABLE_ENTRIES-1:0] status_table_i,
    output logic                          pin_o,
    output logic                          pin_oe_o,
    output logic                          ctrl_we_o,
    output logic [TABLE_INDEX_MSB:0]      ctrl_idx_o,
    output logic                          ctrl_val_o
);
    logic                     pin_r;
    logic                     pin_nxt;
    logic                     oe_r;
    logic                     oe_nxt;
    logic [TABLE_INDEX_MSB:0] idx;
    logic                     dir;

    // ==========================================================
    // Field decode
    assign idx = map_i[TABLE_INDEX_MSB:0];
    assign dir = map_i[DIRECTION_BIT];

    always_comb begin
        pin_nxt = 1'b0;
        oe_nxt  = 1'b0;
        if (dir == DIR_STATUS) begin
            pin_nxt = status_table_i[idx];
            oe_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_r <= 1'b0;
            oe_r  <= 1'b0;
        end else if (ce_i) begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign pin_o      = pin_r;
    assign pin_oe_o   = oe_r;
    assign ctrl_we_o  = (map_i != REG_RESET_VALUE) && (dir == DIR_CONTROL);
    assign ctrl_idx_o = idx;
    assign ctrl_val_o = pin_sync_i;
endmodule

// file: gmsc_chk_sva.sv
// Assertion checker for the pin map and spur register group
module gmsc_chk
    import gmsc_pkg::*;
(
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire logic                     ce_i,
    input wire logic                     reg_wr_i,
    input wire logic                     reg_rd_i,
    input wire logic [7:0]               reg_addr_i,
    input wire logic [7:0]               reg_wdata_i,
    input wire logic [7:0]               reg_rdata_o,
    input wire logic                     reconfig_busy_o,
    input wire logic [7:0]               spur_setting_o,
    input wire logic [TABLE_ENTRIES-1:0] status_table_i,
    input wire logic [TABLE_ENTRIES-1:0] control_table_o,
    input wire logic                     general_pin_ten_i,
    input wire logic                     general_pin_nine_o,
    input wire logic                     general_pin_nine_oe_o
);
    logic [7:0] m9_r, m9_nxt, m10_r, m10_nxt;
    logic       tk;
    logic       sel9;
    // ====================
    // Shadow of two pin maps
    assign tk = ce_i && reg_wr_i && !reconfig_busy_o;
    assign sel9 = status_table_i[m9_r[TABLE_INDEX_MSB:0]];
    always_comb begin
        m9_nxt = (tk && reg_addr_i == PIN9_FUNCTION_MAP_ADDR) ? reg_wdata_i : m9_r;
        m10_nxt = (tk && reg_addr_i == PIN10_FUNCTION_MAP_ADDR) ? reg_wdata_i : m10_r;
        if (!rst_n_i) begin
            m9_nxt = 8'h00;
            m10_nxt = 8'h00;
        end
    end
    always_ff @(posedge clk_i) begin
        m9_r <= m9_nxt;
        m10_r <= m10_nxt;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence spur_change;
        tk && reg_addr_i == SPUR_REDUCTION_SETTING_ADDR && reg_wdata_i != spur_setting_o;
    endsequence
    sequence ten_settled;
        (ce_i && $stable(general_pin_ten_i) && $stable(m10_r))[*7];
    endsequence
    // ====================
    // Properties
    a_rst_clear: assert property (disable iff (1'b0) !rst_n_i && ce_i |=>
        reg_rdata_o == 8'h00 && !reconfig_busy_o && spur_setting_o == 8'h00
        && !general_pin_nine_oe_o) else $error("reset state wrong");
    a_busy_start: assert property (spur_change |=> reconfig_busy_o
        && spur_setting_o == $past(reg_wdata_i)) else $error("reconfig not started");
    a_busy_hold: assert property ($rose(reconfig_busy_o) |->
        reconfig_busy_o[*8]) else $error("reconfig ended early");
    a_spur_frozen: assert property (reconfig_busy_o && $past(reconfig_busy_o) |->
        $stable(spur_setting_o)) else $error("spur changed while busy");
    a_rd_refused: assert property (reconfig_busy_o && ce_i && reg_rd_i |=>
        $stable(reg_rdata_o)) else $error("read taken while busy");
    a_dir_follow: assert property (tk && reg_addr_i == PIN9_FUNCTION_MAP_ADDR ##1 ce_i |=>
        general_pin_nine_oe_o == $past(reg_wdata_i[7], 2)) else $error("direction wrong");
    a_status_follow: assert property (general_pin_nine_oe_o && $past(ce_i) |->
        general_pin_nine_o == $past(sel9)) else $error("status pin wrong");
    a_ctrl_drive: assert property (ten_settled ##0 (m10_r != 8'h00 && !m10_r[7]) |->
        control_table_o[m10_r[6:0]] == general_pin_ten_i) else $error("control bit wrong");
endmodule
bind gmsc_top gmsc_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reconfig_busy_o(reconfig_busy_o),
    .spur_setting_o(spur_setting_o), .status_table_i(status_table_i),
    .control_table_o(control_table_o), .general_pin_ten_i(general_pin_ten_i),
    .general_pin_nine_o(general_pin_nine_o), .general_pin_nine_oe_o(general_pin_nine_oe_o));

// file: gmsc_host.sv
// Host model driving the register port
module gmsc_host (
    input  wire logic       clk_i,
    input  wire logic       busy_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0,
    output logic [7:0]      addr_o = 8'h00,
    output logic [7:0]      wdata_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // Only spur value loaded, reference assumed 10 MHz
    parameter logic [7:0] SPUR_VALUE = 8'h5a;
    // ====================
    // One access, waits out reconfiguration unless forced
    task automatic acc(input logic w, input logic [7:0] a, d, input bit f,
                       output logic [7:0] q);
        while (busy_i && !f) @(posedge clk_i);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1 q = rdata_i;
    endtask
endmodule

// file: tb_top.sv
// Testbench for the pin map and spur register group
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gmsc_pkg::*;
    typedef struct packed {logic [7:0] a, d, e;} gmsc_row_s;
    logic                     clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
    logic                     wr, rd, busy, o9, oe9, o10, oe10, o11, oe11;
    logic                     p9 = 1'b0, p10 = 1'b0, p11 = 1'b0;
    logic [7:0]               addr, wdata, rdata, spur, q;
    logic [TABLE_ENTRIES-1:0] st = '0, ctl;
    int                       fails = 0, comparisons = 0, cyc = 0;
    gmsc_row_s                rows [4] = '{'{8'he9, 8'h85, 8'h85}, '{8'hea, 8'h0a, 8'h0a},
                                           '{8'heb, 8'hff, 8'hff}, '{8'h55, 8'h3c, 8'h00}};
    gmsc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reconfig_busy_o(busy), .spur_setting_o(spur), .status_table_i(st),
        .control_table_o(ctl), .general_pin_nine_i(p9), .general_pin_nine_o(o9),
        .general_pin_nine_oe_o(oe9), .general_pin_ten_i(p10), .general_pin_ten_o(o10),
        .general_pin_ten_oe_o(oe10), .general_pin_eleven_i(p11),
        .general_pin_eleven_o(o11), .general_pin_eleven_oe_o(oe11));
    gmsc_host u_host (.clk_i(clk_i), .busy_i(busy), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    // ====================
    // Clock, timeout and checks
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ====================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            u_host.acc(1'b0, rows[i].a, 8'h00, 1'b0, q);
            chk(q, REG_RESET_VALUE);
        end
        u_host.acc(1'b0, SPUR_REDUCTION_SETTING_ADDR, 8'h00, 1'b0, q);
        chk(q, REG_RESET_VALUE);
        chk({5'h00, oe9, oe10, oe11}, 8'h00);
        foreach (rows[i]) begin
            u_host.acc(1'b1, rows[i].a, rows[i].d, 1'b0, q);
            u_host.acc(1'b0, rows[i].a, 8'h00, 1'b0, q);
            chk(q, rows[i].e);
        end
        u_host.acc(1'b0, PIN9_FUNCTION_MAP_ADDR, 8'h00, 1'b0, q);
        chk(q, 8'h85);
        chk({5'h00, oe9, oe10, oe11}, 8'h05);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            st[5] <= !k[0];
            st[127] <= k[0];
            repeat (3) @(posedge clk_i);
            #1 chk({6'h00, o9, o11}, k[0] ? 8'h01 : 8'h02);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            p10 <= !k[0];
            repeat (8) @(posedge clk_i);
            #1 chk({7'h00, ctl[10]}, {7'h00, !k[0]});
        end
        u_host.acc(1'b1, SPUR_REDUCTION_SETTING_ADDR, REG_RESET_VALUE, 1'b0, q);
        chk({7'h00, busy}, 8'h00);
        @(posedge clk_i);
        ce_i <= 1'b0;
        u_host.acc(1'b1, PIN9_FUNCTION_MAP_ADDR, 8'h00, 1'b0, q);
        @(posedge clk_i);
        ce_i <= 1'b1;
        u_host.acc(1'b0, PIN9_FUNCTION_MAP_ADDR, 8'h00, 1'b0, q);
        chk(q, 8'h85);
        u_host.acc(1'b1, SPUR_REDUCTION_SETTING_ADDR, u_host.SPUR_VALUE, 1'b0, q);
        chk(spur, u_host.SPUR_VALUE);
        u_host.acc(1'b1, PIN9_FUNCTION_MAP_ADDR, 8'h00, 1'b1, q);
        u_host.acc(1'b0, PIN10_FUNCTION_MAP_ADDR, 8'h00, 1'b1, q);
        chk(q, 8'h85);
        repeat (1000) @(posedge clk_i);
        #1 chk({6'h00, busy, oe9}, 8'h03);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1 chk({6'h00, busy, oe9}, 8'h00);
        u_host.acc(1'b0, SPUR_REDUCTION_SETTING_ADDR, 8'h00, 1'b0, q);
        chk(q, REG_RESET_VALUE);
        u_host.acc(1'b1, PIN10_FUNCTION_MAP_ADDR, 8'hff, 1'b0, q);
        u_host.acc(1'b1, PIN11_FUNCTION_MAP_ADDR, 8'h03, 1'b0, q);
        @(posedge clk_i);
        p11 <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1 chk({4'h0, ctl[3], o10, oe10, oe11}, 8'h0e);
        finish_test();
    end
endmodule
